// ---- shared/vic_pkg.sv ----
// vic_pkg: register map, field positions and vectors of the vectored interrupt controller
package vic_pkg;
  localparam logic [11:0] first_ctrl_off = 12'h02c;
  localparam logic [11:0] second_ctrl_off = 12'h078;
  localparam logic [11:0] stack_off = 12'h080;
  localparam logic [11:0] pin_off = 12'h084;
  localparam int first_ctrl_idx = 'h0b;
  localparam int second_ctrl_idx = 'h1e;
  localparam int gie_bit = 0;
  localparam int eie_bit = 1;
  localparam int t0e_bit = 2;
  localparam int t1e_bit = 3;
  localparam int eif_bit = 4;
  localparam int t0f_bit = 5;
  localparam int t1f_bit = 6;
  localparam int test_bit = 7;
  localparam int ade_bit = 0;
  localparam int adf_bit = 4;
  localparam logic [7:0] first_ctrl_rst = 8'h00;
  localparam logic [7:0] second_ctrl_rst = 8'h00;
  localparam logic [7:0] second_ctrl_mask = 8'h11;
  localparam logic [10:0] vec_ext = 11'h004;
  localparam logic [10:0] vec_t0 = 11'h008;
  localparam logic [10:0] vec_t1 = 11'h00c;
  localparam logic [10:0] vec_adc = 11'h010;
  localparam int stack_depth = 4;
  typedef enum logic [1:0] {vic_edge_fall, vic_edge_rise, vic_edge_both} vic_edge_e;
  typedef struct packed {
    logic ext_pin;
    logic timer0_ovf;
    logic timer1_ovf;
    logic adc_done;
  } vic_src_s;
  typedef struct packed {
    logic ack;
    logic [10:0] vector;
  } vic_call_s;
endpackage : vic_pkg

// ---- hw/vic_ctrl.sv ----
// vic_ctrl: four-source vectored interrupt controller with apb register access
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - second control bit 0 enables the conversion-done interrupt
// - second control bit 4 is conversion flag; other bits read zero
// - with global enable clear, new requests only set their flags
// - no acknowledge while the return stack is full
// - acknowledge pushes only the program counter, then branches to vector
// - external pin edge (fall, rise or both) sets external flag bit 4
// - external acknowledge calls 04h, clears its flag and global enable
// - timer 0 overflow sets bit 5; acknowledge calls 08h, clears flag, global
// - timer 1 uses bit 6 and vector 0ch
// - conversion done sets flag; acknowledge calls 10h, clears flag, global
// - acknowledges held until return-from-interrupt or enables set again
// - interrupt return sets global enable; plain return leaves it
// - request arising between phase two edges serviced at the later edge
// - fixed priority external, timer 0, timer 1, conversion; global masks all
// - flags stay set until serviced or cleared by software
// - interrupt, port a falling edge, watchdog or timer flag rise wakes
// - first control: bit 0 global, bits 1-3 source enables, bit 7 test
module vic_ctrl #(
  parameter int pc_width = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vic_pkg::vic_src_s src,
  input wire vic_pkg::vic_edge_e ext_edge_sel,
  input wire logic phase_two_clock,
  input wire logic [pc_width-1:0] pc_in,
  input wire logic stack_pointer_dec,
  input wire logic stack_pointer_inc,
  input wire logic irq_return_instruction,
  input wire logic subroutine_return_instruction,
  input wire logic [7:0] port_a_pins,
  input wire logic watchdog_ovf,
  output vic_pkg::vic_call_s call_q,
  output logic [pc_width-1:0] push_pc_q,
  output logic wake_q
);
  logic [7:0] first_q;
  logic [7:0] second_q;
  logic [2:0] depth_q;
  logic ext_prev_q;
  logic [7:0] pa_prev_q;
  logic t2_prev_q;
  logic wr_en;
  logic rd_en;
  logic stack_full;
  logic t2_rise;
  logic ext_edge;
  logic [3:0] elig;
  logic take;
  logic [3:0] grant;
  logic [3:0] set_flags;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & pstrb[0];
  assign rd_en = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & (paddr != vic_pkg::first_ctrl_off) & (paddr != vic_pkg::second_ctrl_off)
    & (paddr != vic_pkg::stack_off) & (paddr != vic_pkg::pin_off);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        vic_pkg::first_ctrl_off: prdata <= {24'h00_0000, first_q};
        vic_pkg::second_ctrl_off: prdata <= {24'h00_0000, second_q & vic_pkg::second_ctrl_mask};
        vic_pkg::stack_off: prdata <= {29'h0000_0000, depth_q};
        vic_pkg::pin_off: prdata <= {30'h0000_0000, ext_edge_sel};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // events and arbitration
  assign t2_rise = phase_two_clock & ~t2_prev_q;
  assign ext_edge = (ext_edge_sel != vic_pkg::vic_edge_rise && ext_prev_q && !src.ext_pin)
    || (ext_edge_sel != vic_pkg::vic_edge_fall && !ext_prev_q && src.ext_pin);
  assign set_flags = {ext_edge, src.timer0_ovf, src.timer1_ovf, src.adc_done};
  assign stack_full = (depth_q == 3'(vic_pkg::stack_depth));
  assign elig[3] = first_q[vic_pkg::eif_bit] & first_q[vic_pkg::eie_bit];
  assign elig[2] = first_q[vic_pkg::t0f_bit] & first_q[vic_pkg::t0e_bit];
  assign elig[1] = first_q[vic_pkg::t1f_bit] & first_q[vic_pkg::t1e_bit];
  assign elig[0] = second_q[vic_pkg::adf_bit] & second_q[vic_pkg::ade_bit];
  assign take = t2_rise & first_q[vic_pkg::gie_bit] & ~stack_full & (|elig) & ~call_q.ack;
  always_comb begin
    grant = 4'h0;
    if (elig[3]) grant = 4'h8;
    else if (elig[2]) grant = 4'h4;
    else if (elig[1]) grant = 4'h2;
    else if (elig[0]) grant = 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_q <= 1'b1;
      pa_prev_q <= 8'h00;
      t2_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= src.ext_pin;
      pa_prev_q <= port_a_pins;
      t2_prev_q <= phase_two_clock;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= vic_pkg::first_ctrl_rst;
    end else begin
      if (wr_en && paddr == vic_pkg::first_ctrl_off) first_q <= pwdata[7:0];
      if (take) begin
        first_q[vic_pkg::gie_bit] <= 1'b0;
        if (grant[3]) first_q[vic_pkg::eif_bit] <= 1'b0;
        if (grant[2]) first_q[vic_pkg::t0f_bit] <= 1'b0;
        if (grant[1]) first_q[vic_pkg::t1f_bit] <= 1'b0;
      end else if (irq_return_instruction) begin
        first_q[vic_pkg::gie_bit] <= 1'b1;
      end
      if (set_flags[3]) first_q[vic_pkg::eif_bit] <= 1'b1;
      if (set_flags[2]) first_q[vic_pkg::t0f_bit] <= 1'b1;
      if (set_flags[1]) first_q[vic_pkg::t1f_bit] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_q <= vic_pkg::second_ctrl_rst;
    end else begin
      if (wr_en && paddr == vic_pkg::second_ctrl_off) second_q <= pwdata[7:0] & vic_pkg::second_ctrl_mask;
      if (take && grant[0]) second_q[vic_pkg::adf_bit] <= 1'b0;
      if (set_flags[0]) second_q[vic_pkg::adf_bit] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stack depth, call request and wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_q <= 3'h0;
    end else if ((take || stack_pointer_inc) && !stack_pointer_dec && !stack_full) begin
      depth_q <= depth_q + 3'h1;
    end else if (stack_pointer_dec && !(take || stack_pointer_inc) && depth_q != 3'h0) begin
      depth_q <= depth_q - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_q <= '0;
      push_pc_q <= '0;
    end else begin
      call_q.ack <= take;
      if (take) begin
        push_pc_q <= pc_in;
        unique case (1'b1)
          grant[3]: call_q.vector <= vic_pkg::vec_ext;
          grant[2]: call_q.vector <= vic_pkg::vec_t0;
          grant[1]: call_q.vector <= vic_pkg::vec_t1;
          default: call_q.vector <= vic_pkg::vec_adc;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= (|set_flags) | (|(pa_prev_q & ~port_a_pins)) | watchdog_ovf;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks: vectors, stack and global enable
  full_block_a: assert property (@(posedge pclk) disable iff (!presetn) stack_full |-> ##1 !call_q.ack)
    else $error("acknowledge while stack full");

  ack_gie_a: assert property (@(posedge pclk) disable iff (!presetn) take |=> !first_q[vic_pkg::gie_bit])
    else $error("global enable not cleared on acknowledge");

  ext_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && grant[3] |=> call_q.ack && call_q.vector == 11'h004)
    else $error("external vector wrong");

  t0_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && grant[2] |=> call_q.vector == 11'h008 && (!first_q[5] || $past(src.timer0_ovf)))
    else $error("timer 0 vector or flag wrong");

  t1_vec_a: assert property (@(posedge pclk) disable iff (!presetn) take && grant[1] |=> call_q.vector == 11'h00c)
    else $error("timer 1 vector wrong");

  adc_vec_a: assert property (@(posedge pclk) disable iff (!presetn) take && grant[0] |=> call_q.vector == 11'h010)
    else $error("conversion vector wrong");

  irq_return_instruction_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_return_instruction && !take |=> first_q[0])
    else $error("interrupt return did not set global enable");

  no_gie_a: assert property (@(posedge pclk) disable iff (!presetn) !first_q[0] |=> !call_q.ack)
    else $error("acknowledge with global enable clear");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_q[4] && !take && !wr_en |=> first_q[4])
    else $error("external flag lost");

  adc_read_a: assert property (@(posedge pclk) disable iff (!presetn) (second_q & 8'hee) == 8'h00)
    else $error("unused bits set");

  prio_a: assert property (@(posedge pclk) disable iff (!presetn) take && elig[3] |-> grant == 4'h8)
    else $error("priority wrong");

  t2_only_a: assert property (@(posedge pclk) disable iff (!presetn) take |-> $rose(phase_two_clock))
    else $error("service off phase edge");

  wake_ovf_a: assert property (@(posedge pclk) disable iff (!presetn) watchdog_ovf |=> wake_q)
    else $error("no wake");

  //////////////////////////////////////////////////////////////////////////////
  // checks: flags, arbitration and wake
  ext_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_edge |=> first_q[vic_pkg::eif_bit])
    else $error("external edge did not set its flag");

  ext_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && grant[3] && !ext_edge |=> !first_q[vic_pkg::eif_bit])
    else $error("external flag not cleared on acknowledge");

  t0_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.timer0_ovf |=> first_q[vic_pkg::t0f_bit])
    else $error("timer 0 overflow did not set its flag");

  t0_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && grant[2] && !src.timer0_ovf |=> !first_q[vic_pkg::t0f_bit])
    else $error("timer 0 flag not cleared on acknowledge");

  t1_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.timer1_ovf |=> first_q[vic_pkg::t1f_bit])
    else $error("timer 1 overflow did not set its flag");

  t1_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && grant[1] && !src.timer1_ovf |=> !first_q[vic_pkg::t1f_bit])
    else $error("timer 1 flag not cleared on acknowledge");

  adc_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.adc_done |=> second_q[vic_pkg::adf_bit])
    else $error("conversion done did not set its flag");

  adc_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && grant[0] && !src.adc_done |=> !second_q[vic_pkg::adf_bit])
    else $error("conversion flag not cleared on acknowledge");

  adc_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && grant[0] |-> second_q[vic_pkg::ade_bit])
    else $error("conversion serviced while disabled");

  ack_elig_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |-> $onehot(grant) && (grant & elig) == grant)
    else $error("grant to a source that is not eligible");

  prio_t0_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && !elig[3] && elig[2] |-> grant == 4'h4)
    else $error("timer 0 priority wrong");

  gie_mask_a: assert property (@(posedge pclk) disable iff (!presetn) !first_q[vic_pkg::gie_bit] |-> !take)
    else $error("service with global enable clear");

  push_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> call_q.ack && push_pc_q == $past(pc_in))
    else $error("pushed program counter wrong");

  ack_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    call_q.ack |=> !call_q.ack)
    else $error("acknowledge longer than one cycle");

  ret_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
    subroutine_return_instruction && !irq_return_instruction && !take && !wr_en |=> first_q[0] == $past(first_q[0]))
    else $error("plain return changed global enable");

  depth_max_a: assert property (@(posedge pclk) disable iff (!presetn) depth_q <= 3'(vic_pkg::stack_depth))
    else $error("stack depth beyond its limit");

  stack_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && !stack_pointer_dec |=> depth_q == $past(depth_q) + 3'h1)
    else $error("acknowledge did not push");

  wake_pa_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(pa_prev_q & ~port_a_pins)) |=> wake_q)
    else $error("no wake on port a falling edge");

  wake_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.adc_done |=> wake_q)
    else $error("no wake on conversion done");
endmodule : vic_ctrl
`default_nettype wire

// ---- verif/vic_core_model.sv ----
// vic_core_model: sequencer side that makes the phase two clock and the program counter
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire vic_pkg::vic_call_s call,
  output logic phase_two_clock,
  output logic [10:0] pc_in
);
  logic [1:0] phase_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 2'h0;
      pc_in <= 11'h000;
    end else begin
      phase_q <= phase_q + 2'h1;
      pc_in <= call.ack ? call.vector : pc_in + 11'h001;
    end
  end
  assign phase_two_clock = phase_q[1];
endmodule : vic_core_model
`default_nettype wire

// ---- verif/vectored_interrupt_control_bench.sv ----
// vectored_interrupt_control_bench: self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("unexpected %0t: %h not %h", $time, a, b); end end
module vectored_interrupt_control_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rti = 0, srt = 0, spi = 0, spd = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, e32;
  logic pready, pslverr, t2;
  logic [10:0] pc, e11, push_pc;
  logic [10:0] pc_last = 11'h000;
  logic wake, mapped, wdt = 0;
  logic [7:0] pa = 8'hff;
  vic_pkg::vic_edge_e esel = vic_pkg::vic_edge_fall;
  logic [10:0] vecs [4] = '{vic_pkg::vec_ext, vic_pkg::vec_t0, vic_pkg::vec_t1, vic_pkg::vec_adc};
  vic_pkg::vic_src_s src = '{1'b1, 1'b0, 1'b0, 1'b0};
  vic_pkg::vic_call_s call;
  int n_errors = 0, total_checks = 0, cyc = 0;
  logic [31:0] exp_rd[$];
  logic [10:0] exp_vec[$];
  always #2 pclk = ~pclk;
  vic_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src(src), .ext_edge_sel(esel), .phase_two_clock(t2), .pc_in(pc),
    .stack_pointer_dec(spd), .stack_pointer_inc(spi), .irq_return_instruction(rti),
    .subroutine_return_instruction(srt), .port_a_pins(pa), .watchdog_ovf(wdt),
    .call_q(call), .push_pc_q(push_pc), .wake_q(wake));
  vic_core_model u_core (.pclk(pclk), .presetn(presetn), .call(call), .phase_two_clock(t2), .pc_in(pc));
  task stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  always @(posedge pclk) begin
    mapped = paddr inside {vic_pkg::first_ctrl_off, vic_pkg::second_ctrl_off,
      vic_pkg::stack_off, vic_pkg::pin_off};
    if (psel && penable && pready) `CHK(pslverr, !mapped)
    if (psel && penable && !pwrite && pready) begin
      if (exp_rd.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        e32 = exp_rd.pop_front();
        `CHK(prdata, e32)
      end
    end
    if (call.ack === 1'b1) begin
      if (exp_vec.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        e11 = exp_vec.pop_front();
        `CHK(call.vector, e11)
      end
      `CHK(push_pc, pc_last)
    end
    pc_last <= pc;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_empty;
    while (exp_vec.size() != 0) begin
      @(posedge pclk);
    end
  endtask : wait_empty
  initial begin
    logic [31:0] r;
    r = $urandom(27670);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(vic_pkg::first_ctrl_off, 32'h0);
    rd(vic_pkg::second_ctrl_off, 32'h0);
    r = $urandom();
    apb(1'b1, vic_pkg::second_ctrl_off, r);
    rd(vic_pkg::second_ctrl_off, {24'h0, r[7:0] & vic_pkg::second_ctrl_mask});
    apb(1'b1, vic_pkg::first_ctrl_off, 32'h0e);
    apb(1'b1, vic_pkg::second_ctrl_off, 32'h01);
    src <= '{1'b0, 1'b1, 1'b1, 1'b1};
    @(posedge pclk);
    src <= '{1'b0, 1'b0, 1'b0, 1'b0};
    repeat (12) @(posedge pclk);
    rd(vic_pkg::first_ctrl_off, 32'h7e);
    rd(vic_pkg::second_ctrl_off, 32'h11);
    exp_vec.push_back(vecs[0]);
    apb(1'b1, vic_pkg::first_ctrl_off, 32'h7f);
    for (int i = 1; i <= 4; i++) begin
      wait_empty();
      if (i < 4) exp_vec.push_back(vecs[i]);
      rti <= 1'b1; spd <= 1'b1;
      @(posedge pclk);
      rti <= 1'b0; spd <= 1'b0;
    end
    rd(vic_pkg::first_ctrl_off, 32'h0f);
    rd(vic_pkg::second_ctrl_off, 32'h01);
    spi <= 1'b1;
    repeat (4) @(posedge pclk);
    spi <= 1'b0; src.timer0_ovf <= 1'b1;
    @(posedge pclk);
    src.timer0_ovf <= 1'b0;
    repeat (12) @(posedge pclk);
    rd(vic_pkg::stack_off, 32'h4);
    exp_vec.push_back(vecs[1]);
    spd <= 1'b1;
    @(posedge pclk);
    spd <= 1'b0;
    wait_empty();
    srt <= 1'b1; spd <= 1'b1;
    @(posedge pclk);
    srt <= 1'b0; spd <= 1'b0;
    rd(vic_pkg::first_ctrl_off, 32'h0e);
    rd(12'h040, 32'h0);
    wdt <= 1'b1;
    @(posedge pclk);
    wdt <= 1'b0;
    pa <= 8'hfe;
    @(posedge pclk);
    `CHK(wake, 1'b1)
    @(posedge pclk);
    `CHK(wake, 1'b1)
    @(posedge pclk);
    `CHK(wake, 1'b0)
    pa <= 8'hff;
    esel <= vic_pkg::vic_edge_rise;
    @(posedge pclk);
    src.ext_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(vic_pkg::pin_off, 32'h1);
    rd(vic_pkg::first_ctrl_off, 32'h1e);
    apb(1'b1, vic_pkg::first_ctrl_off, 32'h0e);
    src.ext_pin <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(vic_pkg::first_ctrl_off, 32'h0e);
    esel <= vic_pkg::vic_edge_both;
    @(posedge pclk);
    src.ext_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(vic_pkg::first_ctrl_off, 32'h1e);
    `CHK(exp_vec.size() + exp_rd.size(), 0)
    stop_test();
  end
endmodule : vectored_interrupt_control_bench
`default_nettype wire
